// *** design/acsm_send.sv ***
// Serial character send module: frame sequencing, flags and host port
`timescale 1ns/1ps
module acsm_send (
  // Clock and reset
  input  wire logic                          core_clk_in,
  input  wire logic                          srst_in,
  // Register port
  input  wire logic [acsm_pkg::ADDR_W-1:0]   reg_addr_in,
  input  wire logic [acsm_pkg::DATA_W-1:0]   reg_wdata_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  output logic [acsm_pkg::DATA_W-1:0]        reg_rdata_out,
  // Timing and scanner pins
  input  wire logic                          bit_clock_send_in,
  input  wire logic                          line_unit_addressed_in,
  input  wire logic                          send_module_selected_in,
  // Line and status
  output logic                               serial_out,
  output logic                               send_service_request_n_out,
  output logic                               run_clear_out,
  output logic                               not_long_space_out,
  output logic                               counter_bit4_clear_out
);
  import acsm_pkg::*;

  // Frame table and shift path are built for these widths only
  if (CHAR_W != 5) begin : g_char_w_check
    $error("acsm_send: character width must be five bits");
  end
  if (CNT_W != 6) begin : g_cnt_w_check
    $error("acsm_send: half-unit counter must have six stages");
  end

  // Pin synchronisers: stage one feeds stage two only
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic       clk_prev_q;
  logic       bit_step;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      // Held at the step level so a high pin at release is no edge
      pin_s1_q   <= 3'h1;
      pin_s2_q   <= 3'h1;
      clk_prev_q <= 1'b1;
    end else begin
      pin_s1_q   <= {send_module_selected_in, line_unit_addressed_in, bit_clock_send_in};
      pin_s2_q   <= pin_s1_q;
      clk_prev_q <= pin_s2_q[0];
    end
  end

  // Rising edge of the timing clock becomes a one-cycle step
  assign bit_step = pin_s2_q[0] & ~clk_prev_q;

  logic       line_addr;
  logic       module_sel;
  assign line_addr  = pin_s2_q[1];
  assign module_sel = pin_s2_q[2];

  // Command decode from a write to the command word
  logic             cmd_wr;
  logic [1:0]       cmd_func;
  logic             xmit_cmd;
  logic             space_cmd;
  logic             stop_cmd;

  // One decoder for every function code test of a command write
  function automatic logic func_code_is(input logic [FUNC_W-1:0] func,
                                        input logic [FUNC_W-1:0] code);
    func_code_is = (func == code);
  endfunction : func_code_is

  assign cmd_wr    = reg_wr_in & (reg_addr_in == CMD_OFFSET);
  assign cmd_func  = reg_wdata_in[FUNC_LSB +: FUNC_W];
  // Long space is a transmit function with the space modifier
  assign xmit_cmd  = cmd_wr & (func_code_is(cmd_func, FUNC_XMIT_DATA)
                               | func_code_is(cmd_func, FUNC_XMIT_SPACE));
  assign space_cmd = cmd_wr & func_code_is(cmd_func, FUNC_XMIT_SPACE);
  assign stop_cmd  = cmd_wr & func_code_is(cmd_func, FUNC_STOP);

  // Strobe fall: the write cycle is the acknowledge, the next cycle its fall
  logic xmit_fall_q;
  logic xmit_fall_d;
  logic space_fall_q;
  logic space_fall_d;
  logic stop_fall_q;
  logic stop_fall_d;

  always_comb begin
    xmit_fall_d  = xmit_cmd;
    space_fall_d = space_cmd;
    stop_fall_d  = stop_cmd;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      xmit_fall_q  <= 1'b0;
      space_fall_q <= 1'b0;
      stop_fall_q  <= 1'b0;
    end else begin
      xmit_fall_q  <= xmit_fall_d;
      space_fall_q <= space_fall_d;
      stop_fall_q  <= stop_fall_d;
    end
  end

  // Half-unit counter
  // Steps only on the detected edge, never on the raw pin
  logic [CNT_W-1:0] stage;
  logic             run_q;
  logic             run_d;

  acsm_half_counter u_counter (
    .core_clk_in       (core_clk_in),
    .srst_in           (srst_in),
    .bit_clock_send_in (bit_step),
    .run_in            (run_q),
    .stage_out         (stage)
  );

  logic c0;
  logic c4;
  logic c5;
  logic start_pos;
  assign c0        = stage[CNT_BIT0];
  assign c4        = stage[CNT_BIT4];
  assign c5        = stage[CNT_BIT5];
  assign start_pos = (stage == CNT_START_A) | (stage == CNT_START_B);

  // Control flags
  // Space flag follows the write edge; run and stop the edge after
  logic lsp_q;
  logic lsp_d;
  logic stop_q;
  logic stop_d;

  always_comb begin
    run_d  = run_q;
    lsp_d  = lsp_q;
    stop_d = stop_q;
    if (c4) begin
      run_d = 1'b0;
    end
    // Setting wins over the stage-four clear so a late write is not lost
    if (xmit_fall_q) begin
      run_d  = 1'b1;
      stop_d = 1'b0;
    end
    if (space_cmd) begin
      lsp_d = 1'b1;
    end
    if (stop_cmd) begin
      lsp_d  = 1'b0;
    end
    if (stop_fall_q) begin
      stop_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      run_q  <= RUN_RESET;
      lsp_q  <= LSP_RESET;
      stop_q <= STOP_RESET;
    end else begin
      run_q  <= run_d;
      lsp_q  <= lsp_d;
      stop_q <= stop_d;
    end
  end

  // Character register
  logic [CHAR_W-1:0] char_q;
  logic [CHAR_W-1:0] char_d;
  logic              char_shift_pulse;

  // A write while running reloads the register; the host must wait
  // One shift per pair of steps while data bits are on the line
  assign char_shift_pulse = bit_step & c0 & c4;

  always_comb begin
    char_d = char_q;
    if (xmit_cmd) begin
      char_d = reg_wdata_in[CHAR_LSB +: CHAR_W];
    end else if (char_shift_pulse) begin
      char_d = {1'b0, char_q[CHAR_W-1:1]};
    end
  end

  // Reset clears at once instead of a fast shift clock
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      char_q <= CHAR_RESET;
    end else begin
      char_q <= char_d;
    end
  end

  // Line output
  // Flag pairs override the frame so space and mark hold steady
  logic serial_q;
  logic serial_d;

  always_comb begin
    if (lsp_q && !stop_q) begin
      serial_d = 1'b0;
    end else if (!lsp_q && stop_q) begin
      serial_d = LINE_IDLE;
    end else if (c4) begin
      serial_d = char_q[0];
    end else if (start_pos) begin
      serial_d = 1'b0;
    end else begin
      serial_d = LINE_IDLE;
    end
  end

  // Service request and idle status
  // Registered so the scanner sees a clean level
  logic req_n_q;
  logic req_n_d;
  logic run_clr_q;
  logic lsp_clr_q;
  logic c4_clr_q;

  always_comb begin
    // Host answers with a status read, then a transmit write
    req_n_d = ~(~run_q & ~c4 & line_addr & module_sel & ~stop_q
                & (c5 | ~lsp_q));
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      serial_q  <= LINE_IDLE;
      req_n_q   <= 1'b1;
      run_clr_q <= 1'b1;
      lsp_clr_q <= 1'b1;
      c4_clr_q  <= 1'b1;
    end else begin
      serial_q  <= serial_d;
      req_n_q   <= req_n_d;
      run_clr_q <= ~run_q;
      lsp_clr_q <= ~lsp_q;
      c4_clr_q  <= ~c4;
    end
  end

  // Register read path, data valid the cycle after the strobe
  // Zero outside the slot lets read data be ORed with other slaves
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    if (reg_rd_in && reg_addr_in == STATUS_OFFSET) begin
      rdata_d[ST_RUN_BIT]               = run_q;
      rdata_d[ST_LSP_BIT]               = lsp_q;
      rdata_d[ST_STOP_BIT]              = stop_q;
      rdata_d[ST_IDLE_BIT]              = ~run_q & ~lsp_q & ~c4;
      rdata_d[ST_CNT_LSB +: CNT_W]      = stage;
      rdata_d[ST_CHAR_LSB +: CHAR_W]    = char_q;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out              = rdata_q;
  assign serial_out                 = serial_q;
  assign send_service_request_n_out = req_n_q;
  assign run_clear_out              = run_clr_q;
  assign not_long_space_out         = lsp_clr_q;
  assign counter_bit4_clear_out     = c4_clr_q;
endmodule : acsm_send

// *** design/acsm_pkg.sv ***
// Constants shared by the serial character send module
package acsm_pkg;
  // Register port layout (byte addresses)
  localparam int unsigned ADDR_W          = 4;
  localparam int unsigned DATA_W          = 32;
  localparam logic [3:0]  CMD_OFFSET      = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET   = 4'h4;

  // Command word fields
  localparam int unsigned CHAR_W          = 5;
  localparam int unsigned CHAR_LSB        = 0;
  localparam int unsigned FUNC_LSB        = 8;
  localparam int unsigned FUNC_W          = 2;
  localparam logic [1:0]  FUNC_NONE       = 2'h0;
  localparam logic [1:0]  FUNC_XMIT_DATA  = 2'h1;
  localparam logic [1:0]  FUNC_XMIT_SPACE = 2'h2;
  localparam logic [1:0]  FUNC_STOP       = 2'h3;

  // Status word fields
  localparam int unsigned ST_RUN_BIT      = 0;
  localparam int unsigned ST_LSP_BIT      = 1;
  localparam int unsigned ST_STOP_BIT     = 2;
  localparam int unsigned ST_IDLE_BIT     = 3;
  localparam int unsigned ST_CNT_LSB      = 8;
  localparam int unsigned ST_CHAR_LSB     = 16;

  // Half-unit counter: vector bit i is counter stage i
  localparam int unsigned CNT_W           = 6;
  localparam logic [5:0]  CNT_START_A     = 6'h22;
  localparam logic [5:0]  CNT_START_B     = 6'h03;
  localparam logic [5:0]  CNT_DATA1_A     = 6'h14;
  localparam logic [5:0]  CNT_STOP_A      = 6'h0E;
  localparam logic [5:0]  CNT_STOP_B      = 6'h0F;
  localparam logic [5:0]  CNT_IDLE        = 6'h00;
  localparam logic [5:0]  CNT_SPACE_END   = 6'h20;
  localparam int unsigned CNT_BIT0        = 0;
  localparam int unsigned CNT_BIT4        = 4;
  localparam int unsigned CNT_BIT5        = 5;

  // Values after reset
  localparam logic [5:0]  CNT_RESET       = 6'h00;
  localparam logic [4:0]  CHAR_RESET      = 5'h00;
  localparam logic        RUN_RESET       = 1'b0;
  localparam logic        LSP_RESET       = 1'b0;
  localparam logic        STOP_RESET      = 1'b1;
  localparam logic        LINE_IDLE       = 1'b1;
endpackage : acsm_pkg

// *** design/acsm_half_counter.sv ***
// Six-stage half-unit counter stepping through one character frame
`timescale 1ns/1ps
module acsm_half_counter (
  // Clock and reset
  input  wire logic                     core_clk_in,
  input  wire logic                     srst_in,
  // Step control
  input  wire logic                     bit_clock_send_in,
  input  wire logic                     run_in,
  // Stage outputs
  output logic [acsm_pkg::CNT_W-1:0]    stage_out
);
  import acsm_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // Successor of each frame position; idle positions wait for the run flag
  function automatic logic [CNT_W-1:0] next_pos(input logic [CNT_W-1:0] cur,
                                                 input logic            run);
    case (cur)
      CNT_IDLE, CNT_SPACE_END: next_pos = run ? CNT_START_A : CNT_SPACE_END;
      CNT_START_A: next_pos = CNT_START_B;
      CNT_START_B: next_pos = CNT_DATA1_A;
      6'h1D:       next_pos = CNT_STOP_A;
      CNT_STOP_A:  next_pos = CNT_STOP_B;
      CNT_STOP_B:  next_pos = CNT_IDLE;
      default: begin
        // Data positions 14..1C count upward; any stray code falls back to idle
        if (cur >= CNT_DATA1_A && cur < 6'h1D) begin
          next_pos = cur + 6'h01;
        end else begin
          next_pos = CNT_IDLE;
        end
      end
    endcase
  endfunction : next_pos

  always_comb begin
    cnt_d = cnt_q;
    if (bit_clock_send_in) begin
      cnt_d = next_pos(cnt_q, run_in);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cnt_q <= CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign stage_out = cnt_q;
endmodule : acsm_half_counter

// *** tb/acsm_send_sva.sv ***
// Port-level assertions for the serial character send module
`timescale 1ns/1ps
module acsm_send_sva (
  // Clock and reset
  input wire logic                        core_clk_in,
  input wire logic                        srst_in,
  // Register port
  input wire logic [acsm_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [acsm_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic                        reg_wr_in,
  input wire logic                        reg_rd_in,
  input wire logic [acsm_pkg::DATA_W-1:0] reg_rdata_out,
  // Pins and status
  input wire logic                        line_unit_addressed_in,
  input wire logic                        send_module_selected_in,
  input wire logic                        serial_out,
  input wire logic                        send_service_request_n_out,
  input wire logic                        run_clear_out,
  input wire logic                        not_long_space_out,
  input wire logic                        counter_bit4_clear_out
);
  import acsm_pkg::*;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  logic       wr_cmd;
  logic [1:0] fn;
  assign wr_cmd = reg_wr_in && (reg_addr_in == CMD_OFFSET);
  assign fn     = reg_wdata_in[FUNC_LSB +: FUNC_W];
  chk_rdata_one_slot: assert property (!$past(reg_rd_in) |-> reg_rdata_out == '0)
    else $error("read data outside its slot");
  chk_unmapped_zero: assert property (reg_rd_in && reg_addr_in != CMD_OFFSET
    && reg_addr_in != STATUS_OFFSET |=> reg_rdata_out == '0) else $error("unmapped read");
  chk_reset_values: assert property (disable iff (1'b0) srst_in |=> serial_out
    && send_service_request_n_out && run_clear_out && not_long_space_out
    && counter_bit4_clear_out) else $error("reset state wrong");
  chk_req_run_clear: assert property (!send_service_request_n_out |-> run_clear_out
    || $past(run_clear_out)) else $error("request while running");
  chk_req_c4_clear: assert property (!send_service_request_n_out |-> counter_bit4_clear_out
    || $past(counter_bit4_clear_out)) else $error("request during data bits");
  chk_req_scanner: assert property ((!(line_unit_addressed_in && send_module_selected_in))[*5]
    |-> send_service_request_n_out) else $error("request while not addressed");
  chk_run_set: assert property (wr_cmd && (fn == FUNC_XMIT_DATA || fn == FUNC_XMIT_SPACE)
    |-> ##[1:3] !run_clear_out) else $error("run not set by transmit");
  chk_space_set: assert property (wr_cmd && fn == FUNC_XMIT_SPACE
    |-> ##[1:3] !not_long_space_out) else $error("long space not set");
  chk_stop_clr_space: assert property (wr_cmd && fn == FUNC_STOP
    |-> ##[1:3] not_long_space_out) else $error("stop left long space");
  chk_stop_mark: assert property (wr_cmd && fn == FUNC_STOP |-> ##4 serial_out [*8])
    else $error("line not marking after stop");
  chk_c4_drops_run: assert property ($fell(counter_bit4_clear_out) |-> ##[0:2] run_clear_out)
    else $error("run kept in data bits");
  chk_space_low: assert property ((!not_long_space_out)[*4] |-> !serial_out)
    else $error("line not spacing");
endmodule : acsm_send_sva

bind acsm_send acsm_send_sva i_acsm_send_sva (
  .core_clk_in(core_clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .line_unit_addressed_in(line_unit_addressed_in),
  .send_module_selected_in(send_module_selected_in), .serial_out(serial_out),
  .send_service_request_n_out(send_service_request_n_out), .run_clear_out(run_clear_out),
  .not_long_space_out(not_long_space_out), .counter_bit4_clear_out(counter_bit4_clear_out));

// *** tb/acsm_bit_clock_model.sv ***
// Half-unit bit clock source standing in for the timing generator
`timescale 1ns/1ps
module acsm_bit_clock_model #(
  parameter int unsigned HALF_CYC = 10
) (
  input  wire logic clk_in,
  output logic      bit_clock_send_out
);
  // Runs free, unaffected by reset, as the real divider chain does
  int unsigned cnt_q = 0;
  logic        tog_q = 1'b0;
  always_ff @(posedge clk_in) begin
    cnt_q <= (cnt_q == HALF_CYC - 1) ? 0 : cnt_q + 1;
    if (cnt_q == HALF_CYC - 1) begin
      tog_q <= ~tog_q;
    end
  end
  assign bit_clock_send_out = tog_q;
endmodule : acsm_bit_clock_model

// *** tb/acsm_send_tb.sv ***
// Self-checking bench for the serial character send module
`timescale 1ns/1ps
module acsm_send_tb;
  import acsm_pkg::*;
  logic              core_clk_in  = 1'b0;
  logic              srst_in      = 1'b1;
  logic [ADDR_W-1:0] reg_addr_in  = '0;
  logic [DATA_W-1:0] reg_wdata_in = '0;
  logic              reg_wr_in    = 1'b0;
  logic              reg_rd_in    = 1'b0;
  logic              addr_in      = 1'b1;
  logic              sel_in       = 1'b1;
  logic [DATA_W-1:0] reg_rdata_out;
  logic [DATA_W-1:0] rd_v;
  logic              bclk, serial_out, req_n, run_clr, nlsp, c4clr;
  logic [4:0]        chars [3]    = '{5'h15, 5'h0A, 5'h13};
  int                n_fail       = 0;
  int                checks       = 0;
  always #50 core_clk_in = ~core_clk_in;
  acsm_bit_clock_model #(.HALF_CYC(10)) i_acsm_bit_clock_model (.clk_in(core_clk_in),
    .bit_clock_send_out(bclk));
  acsm_send i_acsm_send (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .bit_clock_send_in(bclk),
    .line_unit_addressed_in(addr_in), .send_module_selected_in(sel_in),
    .serial_out(serial_out), .send_service_request_n_out(req_n), .run_clear_out(run_clr),
    .not_long_space_out(nlsp), .counter_bit4_clear_out(c4clr));
  task automatic results;
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in   <= 1'b0;
    @(negedge core_clk_in);
    rd_v = reg_rdata_out;
    @(posedge core_clk_in);
  endtask : rd
  // Samples mid-step; step is one bit clock period of 20 core cycles
  task automatic frame(input logic [4:0] c);
    int         k;
    logic       e;
    logic [2:0] want;
    k = 0;
    while (serial_out !== 1'b0 && k < 400) begin
      @(posedge core_clk_in);
      k++;
    end
    for (int i = 0; i < 15; i++) begin
      repeat (i == 0 ? 10 : 20) @(posedge core_clk_in);
      e = (i < 2) ? 1'b0 : (i < 12) ? c[(i - 2) / 2] : 1'b1;
      // Run clears once data starts; stage four is set only over the data bits
      want = {e, i >= 2, i < 2 || i >= 12};
      cmp(DATA_W'({serial_out, run_clr, c4clr}), DATA_W'(want));
    end
  endtask : frame
  task automatic host_ack;
    int k;
    k = 0;
    while (req_n !== 1'b0 && k < 800) begin
      @(posedge core_clk_in);
      k++;
    end
    cmp(DATA_W'(req_n), '0);
    rd(STATUS_OFFSET);
  endtask : host_ack
  initial begin
    repeat (16) @(posedge core_clk_in);
    srst_in <= 1'b0;
    @(posedge core_clk_in);
    rd(STATUS_OFFSET);
    cmp(rd_v, 32'h0000000C);
    cmp(DATA_W'({serial_out, req_n, run_clr, nlsp, c4clr}), DATA_W'(5'h1F));
    wr(STATUS_OFFSET, '1);
    rd(4'h8);
    cmp(rd_v, '0);
    wr(CMD_OFFSET, {22'h0, FUNC_NONE, 8'h1F});
    rd(STATUS_OFFSET);
    cmp(rd_v, 32'h0000000C);
    for (int i = 0; i < 3; i++) begin
      if (i > 0) host_ack();
      wr(CMD_OFFSET, {22'h0, FUNC_XMIT_DATA, 3'h0, chars[i]});
      frame(chars[i]);
    end
    host_ack();
    cmp(rd_v & 32'h001F000F, 32'h00000008);
    for (int j = 0; j < 2; j++) begin
      if (j > 0) host_ack();
      wr(CMD_OFFSET, {22'h0, FUNC_XMIT_SPACE, 8'h00});
      for (int i = 0; i < 14; i++) begin
        repeat (20) @(posedge core_clk_in);
        cmp(DATA_W'({serial_out, req_n, nlsp}), DATA_W'(3'b010));
      end
    end
    host_ack();
    wr(CMD_OFFSET, {22'h0, FUNC_STOP, 8'h00});
    repeat (5) @(posedge core_clk_in);
    rd(STATUS_OFFSET);
    cmp(rd_v & 32'h6, 32'h4);
    cmp(DATA_W'({serial_out, req_n}), DATA_W'(2'b11));
    // Unselected module must stay quiet after its frame
    sel_in <= 1'b0;
    wr(CMD_OFFSET, {22'h0, FUNC_XMIT_DATA, 8'h0C});
    frame(5'h0C);
    repeat (20) @(posedge core_clk_in);
    cmp(DATA_W'(req_n), DATA_W'(1'b1));
    sel_in  <= 1'b1;
    addr_in <= 1'b0;
    repeat (20) @(posedge core_clk_in);
    cmp(DATA_W'(req_n), DATA_W'(1'b1));
    addr_in <= 1'b1;
    host_ack();
    wr(CMD_OFFSET, {22'h0, FUNC_XMIT_DATA, 8'h1F});
    repeat (60) @(posedge core_clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    srst_in <= 1'b0;
    @(posedge core_clk_in);
    rd(STATUS_OFFSET);
    cmp(rd_v, 32'h0000000C);
    cmp(DATA_W'(serial_out), DATA_W'(1'b1));
    results();
  end
  initial begin
    #3000000;
    n_fail++;
    results();
  end
endmodule : acsm_send_tb
